// [logic/agc_pkg.sv]
// Shared constants and types for the authenticated cipher core
package agc_pkg;
	localparam int WORD_W = 32;
	localparam int BLOCK_W = 128;
	localparam int KEY_W = 128;
	localparam int IV_W = 96;
	localparam int LEN_W = 16;
	localparam int HALF_W = 64;
	localparam int WORD_LOG2 = 5;
	localparam int AES_ROUNDS = 10;
	localparam logic [3:0] ROUND_FIRST = 4'h1;
	localparam logic [1:0] LAST_WORD = 2'h3;
	localparam logic [7:0] GF8_POLY = 8'h1b;
	localparam logic [7:0] SBOX_AFFINE = 8'h63;
	localparam logic [7:0] RCON_FIRST = 8'h01;
	localparam logic [31:0] CTR_FIRST = 32'h00000001;
	localparam logic [127:0] GHASH_R = {8'he1, 120'h0};
	// Bit-serial field product, first bit is the top bit
	function automatic logic [127:0] gfMul(logic [127:0] x, logic [127:0] y);
		logic [127:0] z;
		logic [127:0] v;
		z = '0;
		v = y;
		for (int i = 0; i < 128; i++) begin
			if (x[127 - i])
				z ^= v;
			v = v[0] ? ((v >> 1) ^ GHASH_R) : (v >> 1);
		end
		return z;
	endfunction
	typedef enum logic [2:0] {
		ST_IDLE, ST_KEYS, ST_AAD, ST_MSG, ST_LEN, ST_TAG, ST_DONE
	} agc_state_type;
endpackage

// [logic/agc_cipher.sv]
// Iterative 128-bit-key block cipher, one round per clock
module agc_cipher (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [agc_pkg::KEY_W-1:0] key,
	input wire logic [agc_pkg::BLOCK_W-1:0] blockIn,
	input wire logic take,
	output logic busy,
	output logic resValid,
	output logic [agc_pkg::BLOCK_W-1:0] result
);
	import agc_pkg::*;

	// ----------------------------------------
	// Byte field arithmetic
	// ----------------------------------------
	function automatic logic [7:0] xt(logic [7:0] a);
		return {a[6:0], 1'b0} ^ (a[7] ? GF8_POLY : '0);
	endfunction

	function automatic logic [7:0] gm8(logic [7:0] a, logic [7:0] b);
		logic [7:0] p;
		logic [7:0] t;
		p = '0;
		t = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i])
				p ^= t;
			t = xt(t);
		end
		return p;
	endfunction

	// Inverse as x^254; avoids a 256-entry table per byte lane
	function automatic logic [7:0] sbox(logic [7:0] x);
		logic [7:0] t;
		logic [7:0] r;
		t = gm8(x, x);
		r = t;
		for (int i = 1; i < 7; i++) begin
			t = gm8(t, t);
			r = gm8(r, t);
		end
		return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
			^ {r[3:0], r[7:4]} ^ SBOX_AFFINE;
	endfunction

	function automatic logic [31:0] subWord(logic [31:0] w);
		return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
	endfunction

	function automatic logic [127:0] nextKey(logic [127:0] k, logic [7:0] rc);
		logic [127:0] n;
		n[127:96] = k[127:96] ^ subWord({k[23:0], k[31:24]}) ^ {rc, 24'h0};
		n[95:64] = k[95:64] ^ n[127:96];
		n[63:32] = k[63:32] ^ n[95:64];
		n[31:0] = k[31:0] ^ n[63:32];
		return n;
	endfunction

	function automatic logic [127:0] aesRound(logic [127:0] s,
			logic [127:0] k, logic last);
		logic [7:0] b [16];
		logic [7:0] m [16];
		logic [127:0] o;
		for (int i = 0; i < 16; i++)
			b[i] = sbox(s[127 - 8 * (4 * (((i / 4) + (i % 4)) % 4) + i % 4) -: 8]);
		for (int c = 0; c < 4; c++) begin
			m[4*c] = xt(b[4*c]) ^ xt(b[4*c+1]) ^ b[4*c+1] ^ b[4*c+2] ^ b[4*c+3];
			m[4*c+1] = b[4*c] ^ xt(b[4*c+1]) ^ xt(b[4*c+2]) ^ b[4*c+2] ^ b[4*c+3];
			m[4*c+2] = b[4*c] ^ b[4*c+1] ^ xt(b[4*c+2]) ^ xt(b[4*c+3]) ^ b[4*c+3];
			m[4*c+3] = xt(b[4*c]) ^ b[4*c] ^ b[4*c+1] ^ b[4*c+2] ^ xt(b[4*c+3]);
		end
		for (int i = 0; i < 16; i++)
			o[127 - 8 * i -: 8] = (last ? b[i] : m[i]) ^ k[127 - 8 * i -: 8];
		return o;
	endfunction

	// ----------------------------------------
	// Round datapath
	// ----------------------------------------
	logic [127:0] keyReg;
	logic [7:0] rconReg;
	logic [3:0] roundReg;
	logic [127:0] rkNext;
	logic lastRound;

	assign rkNext = nextKey(keyReg, rconReg);
	assign lastRound = roundReg == 4'(AES_ROUNDS);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result <= '0;
			keyReg <= '0;
			rconReg <= RCON_FIRST;
		end else if (start) begin
			result <= blockIn ^ key;
			keyReg <= key;
			rconReg <= RCON_FIRST;
		end else if (busy) begin
			result <= aesRound(result, rkNext, lastRound);
			keyReg <= rkNext;
			rconReg <= xt(rconReg);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			resValid <= 1'b0;
			roundReg <= ROUND_FIRST;
		end else if (start) begin
			busy <= 1'b1;
			resValid <= 1'b0;
			roundReg <= ROUND_FIRST;
		end else if (busy) begin
			roundReg <= roundReg + 4'h1;
			if (lastRound) begin
				busy <= 1'b0;
				resValid <= 1'b1;
			end
		end else if (take) begin
			resValid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_block_latency: assert property (@(posedge clk) disable iff (reset) // R9
		start ##1 !start [*5] ##1 !start [*5] |=> resValid && !busy)
		else $error("cipher block did not finish in eleven cycles");
	a_key_whitened: assert property (@(posedge clk) disable iff (reset) // R1
		start |=> result == ($past(blockIn) ^ $past(key)) && keyReg == $past(key))
		else $error("cipher did not load key and block");
endmodule

// [logic/agc_core.sv]
// Authenticated counter-mode cipher with Galois hash, word streams
// What this block does
// R1: Every block ciphered with 128-bit key, counter mode
// R2: Encrypt payload and build 128-bit tag
// R3: Decrypt payload, hash received ciphertext and header
// R4: Decrypt compares tag, reports match on status
// R5: No header means all input is payload
// R6: Zero payload means header and tag only, no payload output
// R7: Output header, then payload, then tag, status
// R8: 32-bit word streams in and out
// R9: Long packets approach one block per 11 cycles
// R10: Key, IV, mode loaded before packet words
// R11: Lengths given so length block is hashed
module agc_core (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic decrypt,
	input wire logic [agc_pkg::KEY_W-1:0] key,
	input wire logic [agc_pkg::IV_W-1:0] iv,
	input wire logic [agc_pkg::LEN_W-1:0] aadWords,
	input wire logic [agc_pkg::LEN_W-1:0] msgWords,
	input wire logic [agc_pkg::BLOCK_W-1:0] tagExpected,
	input wire logic [agc_pkg::WORD_W-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [agc_pkg::WORD_W-1:0] outData,
	output logic outValid,
	input wire logic outReady,
	output logic busy,
	output logic tagDone,
	output logic tagMatch
);
	import agc_pkg::*;

	agc_state_type stateReg;
	logic [KEY_W-1:0] keyReg;
	logic [IV_W-1:0] ivReg;
	logic decReg;
	logic [LEN_W-1:0] aadTotal, msgTotal, aadLeft, msgLeft;
	logic [BLOCK_W-1:0] tagExpReg, hReg, ej0Reg, ksReg, ghashReg, blkReg;
	logic [BLOCK_W-1:0] tagReg, blkNext, aesOut, lenBlk;
	logic hHave, ejHave, ksValid, launchedH;
	logic [31:0] ctrReg;
	logic [1:0] wordIdx, tagIdx;
	logic [WORD_W-1:0] ksWord, procWord, ghWord, tagWord;
	logic outValidReg, doneReg, matchReg;
	logic outFree, inFire, sectLast, blockEnd, startAccept;
	logic aesStart, aesTake, aesBusy, aesResValid, working;
	assign outValid = outValidReg;
	assign tagDone = doneReg;
	assign tagMatch = matchReg;
	assign busy = stateReg != ST_IDLE && stateReg != ST_DONE;
	// ----------------------------------------
	// Stream handshake
	// ----------------------------------------
	assign outFree = !outValidReg || outReady;
	assign startAccept = start && !busy;
	// R8 input stalls while the output word is still unread
	assign inReady = outFree
		&& (stateReg == ST_AAD || (stateReg == ST_MSG && ksValid));
	assign inFire = inValid && inReady;
	assign ksWord = ksReg[BLOCK_W - 1 - WORD_W * wordIdx -: WORD_W];
	assign tagWord = tagReg[BLOCK_W - 1 - WORD_W * tagIdx -: WORD_W];
	// R2 R3 payload keyed by counter stream, header passed
	assign procWord = stateReg == ST_MSG ? inData ^ ksWord : inData;
	// R2 R3 hash always covers the ciphertext side
	assign ghWord = (stateReg == ST_MSG && !decReg) ? procWord : inData;
	assign sectLast = stateReg == ST_AAD ? aadLeft == 1 : msgLeft == 1;
	assign blockEnd = inFire && (wordIdx == LAST_WORD || sectLast);
	// R11 length block in bits, both halves
	assign lenBlk = {{(HALF_W - LEN_W - WORD_LOG2){1'b0}}, aadTotal,
		{WORD_LOG2{1'b0}}, {(HALF_W - LEN_W - WORD_LOG2){1'b0}}, msgTotal,
		{WORD_LOG2{1'b0}}};
	always_comb begin
		blkNext = blkReg;
		blkNext[BLOCK_W - 1 - WORD_W * wordIdx -: WORD_W] = ghWord;
	end
	// ----------------------------------------
	// Cipher scheduling
	// ----------------------------------------
	assign working = stateReg == ST_KEYS || stateReg == ST_AAD
		|| stateReg == ST_MSG;
	// R9 next block launched as soon as the last result leaves
	assign aesTake = aesResValid && launchedH && working
		&& (!hHave || !ejHave || !ksValid);
	assign aesStart = working && (!launchedH
		|| (!aesBusy && (!aesResValid || aesTake)));
	agc_cipher u_cipher (
		.clk(clk),
		.reset(reset),
		.start(aesStart),
		.key(keyReg),
		.blockIn(launchedH ? {ivReg, ctrReg} : '0),
		.take(aesTake),
		.busy(aesBusy),
		.resValid(aesResValid),
		.result(aesOut)
	);
	// R1 first hash key, then pre-counter mask, then stream
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			launchedH <= 1'b0;
			ctrReg <= CTR_FIRST;
			hHave <= 1'b0;
			ejHave <= 1'b0;
			ksValid <= 1'b0;
			hReg <= '0;
			ej0Reg <= '0;
			ksReg <= '0;
		end else if (startAccept) begin
			launchedH <= 1'b0;
			ctrReg <= CTR_FIRST;
			hHave <= 1'b0;
			ejHave <= 1'b0;
			ksValid <= 1'b0;
		end else begin
			if (aesStart) begin
				launchedH <= 1'b1;
				if (launchedH)
					ctrReg <= ctrReg + 32'h1;
			end
			if (aesTake && !hHave) begin
				hReg <= aesOut;
				hHave <= 1'b1;
			end else if (aesTake && !ejHave) begin
				ej0Reg <= aesOut;
				ejHave <= 1'b1;
			end else if (aesTake) begin
				ksReg <= aesOut;
				ksValid <= 1'b1;
			end else if (blockEnd && stateReg == ST_MSG) begin
				ksValid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Packet sequencing
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stateReg <= ST_IDLE;
			wordIdx <= '0;
			tagIdx <= '0;
			aadLeft <= '0;
			msgLeft <= '0;
		end else begin
			case (stateReg)
				ST_IDLE, ST_DONE: begin
					if (startAccept) begin
						stateReg <= ST_KEYS;
						aadLeft <= aadWords;
						msgLeft <= msgWords;
						wordIdx <= '0;
					end
				end
				ST_KEYS: begin
					// R5 R6 empty sections skipped
					if (hHave && ejHave)
						stateReg <= aadTotal != 0 ? ST_AAD
							: (msgTotal != 0 ? ST_MSG : ST_LEN);
				end
				ST_AAD, ST_MSG: begin
					if (inFire) begin
						wordIdx <= blockEnd ? '0 : wordIdx + 2'h1;
						if (stateReg == ST_AAD)
							aadLeft <= aadLeft - 1'b1;
						else
							msgLeft <= msgLeft - 1'b1;
						// R7 header before payload before tag
						if (sectLast)
							stateReg <= (stateReg == ST_AAD && msgTotal != 0)
								? ST_MSG : ST_LEN;
					end
				end
				ST_LEN: begin
					stateReg <= ST_TAG;
					tagIdx <= '0;
				end
				ST_TAG: begin
					if (outFree) begin
						tagIdx <= tagIdx + 2'h1;
						if (tagIdx == LAST_WORD)
							stateReg <= ST_DONE;
					end
				end
				default: stateReg <= ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Session parameters and hash
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			keyReg <= '0;
			ivReg <= '0;
			decReg <= 1'b0;
			aadTotal <= '0;
			msgTotal <= '0;
			tagExpReg <= '0;
		end else if (startAccept) begin
			// R10 key, IV, mode and lengths captured at start
			keyReg <= key;
			ivReg <= iv;
			decReg <= decrypt;
			aadTotal <= aadWords;
			msgTotal <= msgWords;
			tagExpReg <= tagExpected;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ghashReg <= '0;
			blkReg <= '0;
			tagReg <= '0;
		end else if (startAccept) begin
			ghashReg <= '0;
			blkReg <= '0;
		end else if (blockEnd) begin
			// Short last block hashed zero padded
			ghashReg <= gfMul(ghashReg ^ blkNext, hReg);
			blkReg <= '0;
		end else if (inFire) begin
			blkReg <= blkNext;
		end else if (stateReg == ST_LEN) begin
			// R11 length block closes the hash
			tagReg <= gfMul(ghashReg ^ lenBlk, hReg) ^ ej0Reg;
		end
	end
	// ----------------------------------------
	// Output word and status
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			outData <= '0;
			outValidReg <= 1'b0;
		end else if (inFire) begin
			outData <= procWord;
			outValidReg <= 1'b1;
		end else if (stateReg == ST_TAG && outFree) begin
			outData <= tagWord;
			outValidReg <= 1'b1;
		end else if (outReady) begin
			outValidReg <= 1'b0;
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			doneReg <= 1'b0;
			matchReg <= 1'b0;
		end else if (startAccept) begin
			doneReg <= 1'b0;
			matchReg <= 1'b0;
		end else if (stateReg == ST_TAG && outFree && tagIdx == LAST_WORD) begin
			// R4 verdict raised with the last tag word
			doneReg <= 1'b1;
			matchReg <= tagReg == tagExpReg;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_in_blocked: assert property (!outFree |-> !inReady) // R8
		else $error("input taken while output word unread");
	a_out_held: assert property ( // R8
		outValidReg && !outReady |=> outValidReg && $stable(outData))
		else $error("output word dropped before read");
	a_aad_passed: assert property ( // R7
		inFire && stateReg == ST_AAD |=> outValidReg
		&& outData == $past(inData))
		else $error("header word not passed through");
	a_msg_keyed: assert property ( // R2
		inFire && stateReg == ST_MSG |-> ksValid
		##1 outData == $past(inData ^ ksWord))
		else $error("payload word not combined with key stream");
	a_in_sections: assert property ( // R5
		inFire |-> stateReg == ST_AAD || stateReg == ST_MSG)
		else $error("input taken outside data sections");
	a_no_payload: assert property (stateReg == ST_MSG |-> msgTotal != 0) // R6
		else $error("payload phase with zero payload length");
	a_tag_last: assert property ( // R7
		stateReg == ST_TAG |-> aadLeft == 0 && msgLeft == 0)
		else $error("tag emitted before data finished");
	a_tag_four: assert property ( // R7
		stateReg == ST_LEN ##1 (stateReg == ST_TAG && outReady) [*4]
		|=> doneReg && stateReg == ST_DONE)
		else $error("tag not four words then done");
	a_len_step: assert property (stateReg == ST_LEN |=> stateReg == ST_TAG) // R11
		else $error("length block not followed by tag");
	a_verdict: assert property ( // R4
		$rose(doneReg) |-> matchReg == (tagReg == tagExpReg))
		else $error("tag verdict does not match comparison");
	c_enc_done: cover property ($rose(doneReg) && !decReg);
	c_dec_pass: cover property ($rose(doneReg) && decReg && matchReg);
	c_dec_fail: cover property ($rose(doneReg) && decReg && !matchReg);
	c_tag_only: cover property ($rose(doneReg) && msgTotal == 0);
endmodule

// [bench/agc_far_end.sv]
// Far-end word feeder and reader for the cipher core streams
module agc_far_end (
	input wire logic clk,
	input wire logic inReady,
	input wire logic [agc_pkg::WORD_W-1:0] outData,
	input wire logic outValid,
	output logic [agc_pkg::WORD_W-1:0] inData,
	output logic inValid,
	output logic outReady
);
	timeunit 1ns;
	timeprecision 1ps;
	import agc_pkg::*;
	logic [WORD_W-1:0] txq[$];
	logic [WORD_W-1:0] rxq[$];
	logic [WORD_W-1:0] outHeld;
	bit slow;
	bit inGo;
	bit outGo;
	initial begin
		slow = 1'b0;
		inGo = 1'b0;
		outGo = 1'b0;
		inData = '0;
		inValid = 1'b0;
		outReady = 1'b0;
		outHeld = '0;
	end
	// --------------------------------
	// Stream handshakes
	// --------------------------------
	// Taken at the edge itself; ready seen at the fall may be stale
	always @(posedge clk) begin
		inGo = inValid && inReady;
		outGo = outValid && outReady;
		outHeld = outData;
	end
	always @(negedge clk) begin
		if (inGo)
			void'(txq.pop_front());
		if (inGo || !inValid) begin
			if (txq.size() != 0 && (!slow || $urandom_range(1) != 0)) begin
				inValid = 1'b1;
				inData = txq[0];
			end else begin
				// Idle bus toggles so stale words never look valid
				inValid = 1'b0;
				inData = ~inData;
			end
		end
		if (outGo)
			rxq.push_back(outHeld);
		outReady = !slow || $urandom_range(1) != 0;
	end
endmodule

// [bench/agc_core_test.sv]
// Self-checking bench for the authenticated cipher core
module agc_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import agc_pkg::*;
	localparam logic [127:0] K4 = 128'hfeffe9928665731c6d6a8f9467308308;
	localparam logic [95:0] V4 = 96'hcafebabefacedbaddecaf888;
	localparam logic [127:0] T4 = 128'h5bc94fbc3221a5db94fae95ae7121a47;
	localparam logic [511:0] TA = {160'hfeedfacedeadbeeffeedfacedeadbeefabaddad2,
		352'h0};
	localparam logic [511:0] TP = {128'hd9313225f88406e5a55909c5aff5269a,
		128'h86a7a9531534f7da2e4c303d8a318a72,
		128'h1c3c0c95956809532fcf0e2449a6b525,
		96'hb16aedf5aa0de657ba637b39, 32'h0};
	localparam logic [511:0] TC = {128'h42831ec2217774244b7221b784d0d49c,
		128'he3aa212f2c02a4e035c17e2329aca12e,
		128'h21d514b25466931c7d8f6a5aac84aa05,
		96'h1ba30b396a0aac973d58e091, 32'h0};
	localparam int LIM = 3000;
	localparam int LONG = 256;
	logic clk;
	logic reset;
	logic start;
	logic decrypt;
	logic [KEY_W-1:0] key;
	logic [IV_W-1:0] iv;
	logic [LEN_W-1:0] aadWords;
	logic [LEN_W-1:0] msgWords;
	logic [BLOCK_W-1:0] tagExpected;
	logic [WORD_W-1:0] inData;
	logic inValid;
	logic inReady;
	logic [WORD_W-1:0] outData;
	logic outValid;
	logic outReady;
	logic busy;
	logic tagDone;
	logic tagMatch;
	int num_errors;
	int tests_run;
	int cyc;
	logic [31:0] txw[$];
	logic [31:0] expw[$];
	logic [31:0] got[$];
	logic [127:0] tag;
	logic [511:0] rnd;
	logic [127:0] rk;

	agc_core u_agc_core (.clk(clk), .reset(reset), .start(start),
		.decrypt(decrypt), .key(key), .iv(iv), .aadWords(aadWords),
		.msgWords(msgWords), .tagExpected(tagExpected), .inData(inData),
		.inValid(inValid), .inReady(inReady), .outData(outData),
		.outValid(outValid), .outReady(outReady), .busy(busy),
		.tagDone(tagDone), .tagMatch(tagMatch));
	agc_far_end u_agc_far_end (.clk(clk), .inReady(inReady),
		.outData(outData), .outValid(outValid), .inData(inData),
		.inValid(inValid), .outReady(outReady));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic check(input logic [127:0] g, input logic [127:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic add(ref logic [31:0] q[$], input logic [511:0] v,
		input int n);
		for (int i = 0; i < n; i++) begin
			q.push_back(v[511-32*i -: 32]);
		end
	endtask

	// One whole packet; a refused start mid-run must change nothing
	task automatic session(input bit dec, input logic [127:0] k,
		input logic [95:0] v, input logic [127:0] te, input int na,
		input int nm, input bit chk, input logic [127:0] et, input bit ok);
		@(negedge clk);
		decrypt = dec;
		key = k;
		iv = v;
		tagExpected = te;
		aadWords = na[15:0];
		msgWords = nm[15:0];
		u_agc_far_end.rxq.delete();
		foreach (txw[i]) u_agc_far_end.txq.push_back(txw[i]);
		start = 1'b1;
		cyc = 0;
		while ((tagDone !== 1'b1 || u_agc_far_end.rxq.size() < na + nm + 4)
			&& cyc < LIM) begin
			@(negedge clk);
			cyc++;
			start = cyc == 5;
			key = (cyc == 5) ? ~k : k;
		end
		txw.delete();
		if (cyc == LIM) begin
			num_errors++;
			summarize();
		end else begin
			got = u_agc_far_end.rxq;
			check(got.size(), na + nm + 4); // word count
			foreach (expw[i]) check(got[i], expw[i]); // data in order
			tag = {got[na+nm], got[na+nm+1], got[na+nm+2], got[na+nm+3]};
			if (chk) check(tag, et); // tag value
			if (dec) check(tagMatch, ok); // match status
			check(busy, 1'b0); // session closed
			expw.delete();
		end
	endtask

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		reset = 1'b1;
		start = 1'b0;
		decrypt = 1'b0;
		key = '0;
		iv = '0;
		aadWords = '0;
		msgWords = '0;
		tagExpected = '0;
		num_errors = 0;
		tests_run = 0;
		void'($urandom(32'hbfd16b67));
		repeat (10) @(negedge clk);
		reset = 1'b0;
		session(0, 0, 0, 0, 0, 0, 1, 128'h58e2fccefa7e3061367f1d57a4e7455a, 0);
		add(txw, 0, 4);
		add(expw, {128'h0388dace60b6a392f328c2b971b2fe78, 384'h0}, 4);
		session(0, 0, 0, 0, 0, 4, 1, 128'hab6e47d42cec13bdf53a67b21257bddf, 0);
		add(txw, TA, 5);
		add(txw, TP, 15);
		add(expw, TA, 5);
		add(expw, TC, 15);
		session(0, K4, V4, 0, 5, 15, 1, T4, 0);
		for (int b = 0; b < 2; b++) begin
			add(txw, TA, 5);
			add(txw, TC, 15);
			add(expw, TA, 5);
			add(expw, TP, 15);
			session(1, K4, V4, T4 ^ b, 5, 15, 1, T4, b == 0);
		end
		// Random round trips under stalls; second has no payload
		u_agc_far_end.slow = 1'b1;
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 16; i++) rnd[32*i +: 32] = $urandom();
			rk = {$urandom(), $urandom(), $urandom(), $urandom()};
			add(txw, rnd, 3 + 9 * (1 - r));
			add(expw, rnd, 3);
			session(0, rk, rnd[95:0], 0, 3, 9 * (1 - r), 0, 0, 0);
			for (int i = 0; i < 3 + 9 * (1 - r); i++) txw.push_back(got[i]);
			add(expw, rnd, 3 + 9 * (1 - r));
			session(1, rk, rnd[95:0], tag, 3, 9 * (1 - r), 1, tag, 1);
		end
		u_agc_far_end.slow = 1'b0;
		for (int i = 0; i < LONG; i++) txw.push_back($urandom());
		session(0, rk, rnd[95:0], 0, 0, LONG, 0, 0, 0);
		check(cyc <= LONG / 4 * 11 + 64, 1'b1); // block rate
		summarize();
	end
endmodule
